// File: hdl/oss_top.sv
// oscillator source select with start-up timer and register slave
//
// The Avalon-MM slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module oss_top
    import oss_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    input  wire logic [2:0]  clock_group_cfg_in,
    input  wire logic [4:0]  primary_mode_cfg_in,
    input  wire logic        osc_tick_in,
    input  wire logic        pll_lock_in,
    input  wire logic        wake_in,
    input  wire logic        power_up_timer_expired_in,
    input  wire logic        wdt_en_in,
    input  wire logic        fail_safe_en_in,
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    output oss_src_t         src_sel_out,
    output logic             osc_clk_release_out,
    output logic [4:0]       pll_mult_out,
    output logic             pll_from_fast_rc_out,
    output logic             secondary_osc_en_out,
    output logic             slow_rc_en_out,
    output logic [5:0]       fast_rc_trim_out,
    output logic [7:0]       fast_rc_offset_out,
    output oss_pins_t        pin_func_out,
    output logic [2:0]       current_group_out
);
    // ==========================================================
    // state
    logic            cfg_loaded;
    logic [2:0]      current_group;
    logic [2:0]      requested_group;
    logic            secondary_osc_keep_on;
    logic [5:0]      fast_rc_trim;
    logic [4:0]      primary_mode;
    oss_ost_t        ost_st;
    logic [OST_W-1:0] ost_cnt;
    logic            tick_s1;
    logic            tick_s2;
    logic            tick_s3;
    logic            lock_s1;
    logic            lock_s2;
    logic            tick_edge;
    logic            xtal_now;
    logic            xtal_next;
    logic            ost_restart;
    logic            sw_acc;
    logic            wr_acc;
    logic [2:0]      next_req;
    logic [2:0]      next_cur;
    logic [31:0]     rd_mux;

    // ==========================================================
    // crystal modes that need the start-up timer
    function automatic logic is_xtal(input logic [2:0] g,
                                     input logic [4:0] m);
        logic pri;
        pri = (g == GRP_PRI) || (g == GRP_PLL);
        if (g == GRP_SEC) begin
            is_xtal = 1'b1;
        end else if (!pri) begin
            is_xtal = 1'b0;
        end else begin
            is_xtal = (m == MODE_XTL) || (m == MODE_HS) ||
                      (m == MODE_XT) ||
                      (m[4:2] == MODE_HS2[4:2] && m[1:0] != 2'h0) ||
                      (m[4:2] == MODE_HS3[4:2] && m[1:0] != 2'h0);
        end
    endfunction

    // ==========================================================
    // synchronisers for the oscillator and lock pins
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tick_s1 <= 1'b0;
            tick_s2 <= 1'b0;
            tick_s3 <= 1'b0;
            lock_s1 <= 1'b0;
            lock_s2 <= 1'b0;
        end else begin
            tick_s1 <= osc_tick_in;
            tick_s2 <= tick_s1;
            tick_s3 <= tick_s2;
            lock_s1 <= pll_lock_in;
            lock_s2 <= lock_s1;
        end
    end
    assign tick_edge = tick_s2 & ~tick_s3;

    // ==========================================================
    // register bus: one wait cycle, then a one-cycle answer
    assign wr_acc = avs_write_in & ~avs_waitrequest_out;
    assign sw_acc = wr_acc && avs_address_in == CTRL_OFS &&
                    avs_byteenable_in[0] && avs_writedata_in[SWITCH_BIT];

    always_comb begin
        next_req = requested_group;
        if (wr_acc && avs_address_in == CTRL_OFS && avs_byteenable_in[1]) begin
            next_req = avs_writedata_in[REQ_LSB +: 3];
        end
        next_cur = sw_acc ? next_req : current_group;
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (avs_address_in)
            CTRL_OFS: begin
                rd_mux[CUR_LSB +: 3] = current_group;
                rd_mux[REQ_LSB +: 3] = requested_group;
                rd_mux[LOCK_BIT]     = lock_s2;
                rd_mux[KEEP_BIT]     = secondary_osc_keep_on;
            end
            TRIM_OFS: begin
                rd_mux[5:0] = fast_rc_trim;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= 32'h0000_0000;
        end else begin
            avs_waitrequest_out <= ~((avs_read_in | avs_write_in) &
                                     avs_waitrequest_out);
            if (avs_read_in && avs_waitrequest_out) begin
                avs_readdata_out <= rd_mux;
            end
        end
    end

    // ==========================================================
    // group selection: config straps caught at the first edge
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_loaded      <= 1'b0;
            current_group   <= GRP_FRC;
            requested_group <= GRP_FRC;
            primary_mode    <= MODE_XTL;
        end else if (!cfg_loaded) begin
            cfg_loaded      <= 1'b1;
            current_group   <= clock_group_cfg_in;
            requested_group <= clock_group_cfg_in;
            primary_mode    <= primary_mode_cfg_in;
        end else begin
            current_group   <= next_cur;
            requested_group <= next_req;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            secondary_osc_keep_on <= KEEP_RST;
            fast_rc_trim          <= TRIM_RST;
        end else if (wr_acc && avs_byteenable_in[0]) begin
            if (avs_address_in == CTRL_OFS) begin
                secondary_osc_keep_on <= avs_writedata_in[KEEP_BIT];
            end
            if (avs_address_in == TRIM_OFS) begin
                fast_rc_trim <= avs_writedata_in[5:0];
            end
        end
    end

    // ==========================================================
    // start-up timer
    // restart on config load, on wake, and on a switch only when the newly selected source is a crystal
    assign xtal_now    = is_xtal(current_group, primary_mode);
    assign xtal_next   = is_xtal(next_req, primary_mode);
    assign ost_restart = !cfg_loaded || wake_in ||
                         (sw_acc && xtal_next);

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ost_st  <= OST_COUNT;
            ost_cnt <= '0;
        end else if (ost_restart) begin
            ost_st  <= OST_COUNT;
            ost_cnt <= '0;
        end else begin
            unique case (ost_st)
                OST_COUNT: begin
                    if (tick_edge) begin
                        ost_cnt <= ost_cnt + 1'b1;
                        if (ost_cnt == OST_LAST) begin
                            ost_st <= OST_DONE;
                        end
                    end
                end
                OST_DONE: begin
                    ost_st <= OST_DONE;
                end
            endcase
        end
    end

    // ==========================================================
    // clock release and source select
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            osc_clk_release_out <= 1'b0;
            src_sel_out         <= '0;
            current_group_out   <= GRP_FRC;
        end else begin
            osc_clk_release_out <= cfg_loaded && !ost_restart &&
                                   (!xtal_now || ost_st == OST_DONE) &&
                                   (current_group != GRP_SEC ||
                                    secondary_osc_keep_on);
            src_sel_out.ext  <= current_group == GRP_PRI;
            src_sel_out.pll  <= current_group == GRP_PLL;
            src_sel_out.sec  <= current_group == GRP_SEC &&
                                secondary_osc_keep_on;
            src_sel_out.fast_internal_rc  <= current_group == GRP_FRC;
            src_sel_out.slow_internal_rc <= current_group == GRP_SLOW_INTERNAL_RC;
            current_group_out <= current_group;
        end
    end

    // ==========================================================
    // pll gain, secondary enable, slow rc enable
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pll_mult_out         <= MULT_X4;
            pll_from_fast_rc_out <= 1'b0;
        end else begin
            unique case (primary_mode[1:0])
                GAIN_X8:  pll_mult_out <= MULT_X8;
                GAIN_X16: pll_mult_out <= MULT_X16;
                default:  pll_mult_out <= MULT_X4;
            endcase
            pll_from_fast_rc_out <= current_group == GRP_PLL &&
                                    primary_mode[4:2] == MODE_FRCP[4:2] &&
                                    primary_mode[1:0] != 2'h0;
        end
    end

    // the keep-on bit alone drives the enable, so sleep does not stop it
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            secondary_osc_en_out <= KEEP_RST;
        end else begin
            secondary_osc_en_out <= secondary_osc_keep_on;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            slow_rc_en_out <= 1'b1;
        end else begin
            slow_rc_en_out <= !power_up_timer_expired_in || fail_safe_en_in ||
                              wdt_en_in ||
                              current_group == GRP_SLOW_INTERNAL_RC;
        end
    end

    // ==========================================================
    // trim encoding and pin functions
    // offset in 0.2 percent units, two per trim step; the two end codes
    // carry an extra half step so the range reaches +12.6 and -13.0
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            fast_rc_trim_out   <= TRIM_RST;
            fast_rc_offset_out <= 8'h00;
        end else begin
            fast_rc_trim_out   <= fast_rc_trim;
            unique case (fast_rc_trim)
                6'h1f:   fast_rc_offset_out <= 8'h3f;
                6'h20:   fast_rc_offset_out <= 8'hbf;
                default: fast_rc_offset_out <= {fast_rc_trim[5],
                                                fast_rc_trim, 1'b0};
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_func_out <= '0;
        end else begin
            pin_func_out.osc_out_pin_gpio <= primary_mode == MODE_EXTERNAL_CLOCK_IO_MODE ||
                primary_mode == MODE_EXTERNAL_RC_IO_MODE ||
                (primary_mode[4:2] == MODE_EXTERNAL_CLOCK_IO_MODE[4:2] &&
                 primary_mode[1:0] != 2'h0) ||
                (primary_mode[4:2] == MODE_FRCP[4:2] &&
                 primary_mode[1:0] != 2'h0);
            pin_func_out.osc_out_pin_clkout <= primary_mode == MODE_EC ||
                                        primary_mode == MODE_ERC;
            pin_func_out.osc_out_pin_xtal <= is_xtal(GRP_PRI, primary_mode);
            pin_func_out.osc_in_pin_gpio <= 1'b0;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence count_end_s;
        ost_st == OST_COUNT && tick_edge && ost_cnt == OST_LAST;
    endsequence
    sequence no_restart_s;
        !ost_restart;
    endsequence

    ost_done_a: assert property (
        (ost_st == OST_DONE && $past(ost_st) == OST_COUNT) |->
            $past(ost_cnt) == OST_LAST)
        else $error("start-up timer ended before 1024 periods");
    ost_finish_a: assert property (
        (count_end_s and no_restart_s) |=> ost_st == OST_DONE)
        else $error("start-up timer missed its last period");
    hold_gate_a: assert property (
        (cfg_loaded && xtal_now && ost_st != OST_DONE) |=>
            !osc_clk_release_out)
        else $error("crystal clock released before start-up count");
    wake_rerun_a: assert property (
        wake_in |=> ost_st == OST_COUNT && ost_cnt == '0)
        else $error("wake did not rerun start-up count");
    return_xtal_a: assert property (
        (sw_acc && xtal_next) |=> ost_st == OST_COUNT ##1
            !osc_clk_release_out)
        else $error("switch to crystal skipped start-up delay");
    no_delay_a: assert property (
        (cfg_loaded && !ost_restart && !xtal_now &&
         current_group != GRP_SEC) |=> osc_clk_release_out)
        else $error("non crystal source was held");
    frc_run_a: assert property (
        current_group == GRP_FRC |=> src_sel_out.fast_internal_rc && !src_sel_out.pll)
        else $error("fast rc not selected for group 001");
    sec_select_a: assert property (
        src_sel_out.sec |-> $past(current_group) == GRP_SEC &&
            $past(secondary_osc_keep_on))
        else $error("secondary selected without keep-on");
    frc_pll16_a: assert property (
        (current_group == GRP_PLL && primary_mode == 5'h07) |=>
            pll_mult_out == MULT_X16 && pll_from_fast_rc_out)
        else $error("fast rc x16 pll not applied");
    slow_internal_rc_keep_a: assert property (
        (power_up_timer_expired_in && !wdt_en_in && !fail_safe_en_in &&
         current_group != GRP_SLOW_INTERNAL_RC) |=> !slow_rc_en_out)
        else $error("slow rc left running without a user");
    strap_load_a: assert property (
        $rose(cfg_loaded) |-> current_group == $past(clock_group_cfg_in)
            && requested_group == $past(clock_group_cfg_in))
        else $error("groups not loaded from config");
    trim_min_a: assert property (
        fast_rc_trim == 6'h20 |=> fast_rc_offset_out == 8'hbf)
        else $error("minimum trim not encoded as -13.0 percent");
    osc_in_pin_fixed_a: assert property (
        !pin_func_out.osc_in_pin_gpio)
        else $error("first oscillator pin turned to gpio");
    keep_on_a: assert property (
        secondary_osc_keep_on |=> secondary_osc_en_out)
        else $error("secondary oscillator off while keep-on set");
    trim_max_a: assert property (
        fast_rc_trim == 6'h1f |=> fast_rc_offset_out == 8'h3f)
        else $error("maximum trim not encoded as +12.6 percent");
    osc_out_pin_io_a: assert property (
        (primary_mode == MODE_EXTERNAL_CLOCK_IO_MODE || primary_mode == MODE_EXTERNAL_RC_IO_MODE) |=>
            pin_func_out.osc_out_pin_gpio && !pin_func_out.osc_out_pin_xtal)
        else $error("second oscillator pin not released to io");
    lock_read_a: assert property (
        (avs_read_in && avs_waitrequest_out && avs_address_in == CTRL_OFS)
            |=> avs_readdata_out[LOCK_BIT] == $past(lock_s2))
        else $error("lock bit read did not show live lock state");
endmodule

// File: hdl/oss_pkg.sv
// constants and types of the oscillator source select block
// Summary of operation
// - at reset the clock source is chosen from group and primary mode fields
// - fast rc runs the device whenever the current group is 001
// - group 111 with mode 00101/00110/00111 gives fast rc pll x4/x8/x16
// - a 10-bit counter waits 1024 oscillator periods before clock release
// - start-up count reruns on power-on, brown-out and wake from sleep
// - start-up delay only for crystal modes, not external, rc or internal
// - secondary crystal runs, even in sleep, while keep-on bit is 1
// - secondary clocks the device only with group 000 and keep-on 1
// - going back to the primary crystal reruns the start-up delay
// - pll gain x4, x8 or x16 is chosen by the primary mode code
// - pll lock follows the loop live and reads in the control register
// - 6-bit trim moves the fast rc in 0.4 percent steps
// - trim is two's complement, 011111 is +12.6, 100000 is -13.0 percent
// - slow rc clocks power-up timer, watchdog, monitor; may be system clock
// - slow rc is always on at power-on to time the power-up delay
// - after power-up slow rc stays on for monitor, watchdog or selection
// - second pin is gpio, clock out or crystal pin by the mode code
// - first oscillator pin never becomes general purpose io
// - at reset both current and requested group load from the config
package oss_pkg;
    // ==========================================================
    // groups and primary modes
    localparam logic [2:0] GRP_SEC  = 3'h0;
    localparam logic [2:0] GRP_FRC  = 3'h1;
    localparam logic [2:0] GRP_SLOW_INTERNAL_RC = 3'h2;
    localparam logic [2:0] GRP_PRI  = 3'h3;
    localparam logic [2:0] GRP_PLL  = 3'h7;
    localparam logic [4:0] MODE_XTL   = 5'h00;
    localparam logic [4:0] MODE_HS    = 5'h02;
    localparam logic [4:0] MODE_XT    = 5'h04;
    localparam logic [4:0] MODE_FRCP  = 5'h04;
    localparam logic [4:0] MODE_EXTERNAL_RC_IO_MODE = 5'h08;
    localparam logic [4:0] MODE_ERC   = 5'h09;
    localparam logic [4:0] MODE_EC    = 5'h0b;
    localparam logic [4:0] MODE_EXTERNAL_CLOCK_IO_MODE  = 5'h0c;
    localparam logic [4:0] MODE_HS2   = 5'h10;
    localparam logic [4:0] MODE_HS3   = 5'h14;
    localparam logic [1:0] GAIN_X4  = 2'h1;
    localparam logic [1:0] GAIN_X8  = 2'h2;
    localparam logic [1:0] GAIN_X16 = 2'h3;
    localparam logic [4:0] MULT_X4  = 5'h04;
    localparam logic [4:0] MULT_X8  = 5'h08;
    localparam logic [4:0] MULT_X16 = 5'h10;
    // ==========================================================
    // register map, fields and reset values
    localparam logic [3:0] CTRL_OFS   = 4'h0;
    localparam logic [3:0] TRIM_OFS   = 4'h4;
    localparam int         CUR_LSB    = 12;
    localparam int         REQ_LSB    = 8;
    localparam int         LOCK_BIT   = 5;
    localparam int         KEEP_BIT   = 1;
    localparam int         SWITCH_BIT = 0;
    localparam logic [5:0] TRIM_RST   = 6'h00;
    localparam logic       KEEP_RST   = 1'b0;
    // ==========================================================
    // start-up timer
    localparam int         OST_W    = 10;
    localparam logic [9:0] OST_LAST = 10'h3ff;
    typedef enum logic [1:0] {
        OST_COUNT = 2'b01,
        OST_DONE  = 2'b10
    } oss_ost_t;
    typedef struct packed {
        logic ext;
        logic pll;
        logic sec;
        logic fast_internal_rc;
        logic slow_internal_rc;
    } oss_src_t;
    typedef struct packed {
        logic osc_out_pin_gpio;
        logic osc_out_pin_clkout;
        logic osc_out_pin_xtal;
        logic osc_in_pin_gpio;
    } oss_pins_t;
endpackage

// File: tb/test_oscillator_source_select.sv
// self-checking testbench of the oscillator source select block
`timescale 1ns/1ps
module test_oscillator_source_select
    import oss_pkg::*;
;
    logic        ref_clk_in;
    logic        rst_in;
    logic [2:0]  clock_group_cfg_in;
    logic [4:0]  primary_mode_cfg_in;
    logic        osc_tick_in;
    logic        pll_lock_in;
    logic        wake_in;
    logic        power_up_timer_expired_in;
    logic        wdt_en_in;
    logic        fail_safe_en_in;
    logic [3:0]  avs_address_in;
    logic        avs_read_in;
    logic        avs_write_in;
    logic [31:0] avs_writedata_in;
    logic [3:0]  avs_byteenable_in;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    oss_src_t    src_sel_out;
    logic        osc_clk_release_out;
    logic [4:0]  pll_mult_out;
    logic        pll_from_fast_rc_out;
    logic        secondary_osc_en_out;
    logic        slow_rc_en_out;
    logic [5:0]  fast_rc_trim_out;
    logic [7:0]  fast_rc_offset_out;
    oss_pins_t   pin_func_out;
    logic [2:0]  current_group_out;
    int          error_cnt;
    int          compares;
    logic [31:0] rd;

    oss_top oss_top_i (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .clock_group_cfg_in(clock_group_cfg_in),
        .primary_mode_cfg_in(primary_mode_cfg_in),
        .osc_tick_in(osc_tick_in), .pll_lock_in(pll_lock_in),
        .wake_in(wake_in), .power_up_timer_expired_in(power_up_timer_expired_in),
        .wdt_en_in(wdt_en_in), .fail_safe_en_in(fail_safe_en_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out),
        .src_sel_out(src_sel_out),
        .osc_clk_release_out(osc_clk_release_out),
        .pll_mult_out(pll_mult_out),
        .pll_from_fast_rc_out(pll_from_fast_rc_out),
        .secondary_osc_en_out(secondary_osc_en_out),
        .slow_rc_en_out(slow_rc_en_out),
        .fast_rc_trim_out(fast_rc_trim_out),
        .fast_rc_offset_out(fast_rc_offset_out),
        .pin_func_out(pin_func_out),
        .current_group_out(current_group_out)
    );

    // ==========================================================
    // clock, compare and closing
    always #5 ref_clk_in = ~ref_clk_in;

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // watchdog: the whole run needs about 8500 cycles
    initial begin
        repeat (60000) @(posedge ref_clk_in);
        error_cnt++;
        end_of_test();
    end

    // ==========================================================
    // bus, reset and oscillator stimulus
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        avs_address_in   <= a;
        avs_writedata_in <= d;
        avs_write_in     <= 1'b1;
        do @(posedge ref_clk_in); while (avs_waitrequest_out !== 1'b0);
        avs_write_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
    endtask

    task automatic bus_rd(input logic [3:0] a);
        @(posedge ref_clk_in);
        avs_address_in <= a;
        avs_read_in    <= 1'b1;
        do @(posedge ref_clk_in); while (avs_waitrequest_out !== 1'b0);
        rd = avs_readdata_out;
        avs_read_in <= 1'b0;
    endtask

    // reset stands in for power-on or brown-out
    task automatic do_reset(input logic [2:0] g, input logic [4:0] m);
        @(posedge ref_clk_in);
        rst_in              <= 1'b1;
        clock_group_cfg_in  <= g;
        primary_mode_cfg_in <= m;
        repeat (16) @(posedge ref_clk_in);
        chk("slow rc in reset", slow_rc_en_out, 1);
        rst_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
    endtask

    // one oscillator period is two reference cycles here
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge ref_clk_in);
            osc_tick_in <= 1'b1;
            @(posedge ref_clk_in);
            osc_tick_in <= 1'b0;
        end
        repeat (6) @(posedge ref_clk_in);
    endtask

    // ==========================================================
    // scenarios
    task automatic test_pll_modes();
        logic [4:0] mult [3];
        mult = '{MULT_X4, MULT_X8, MULT_X16};
        for (int i = 0; i < 3; i++) begin
            do_reset(GRP_PLL, 5'h05 + 5'(i)); // trim at centre
            chk("pll mult", pll_mult_out, mult[i]);
            chk("pll from fast rc", pll_from_fast_rc_out, 1);
            chk("src pll", src_sel_out, 5'h08);
            chk("no start-up wait", osc_clk_release_out, 1);
            chk("pins gpio", pin_func_out, 4'h8);
            bus_rd(CTRL_OFS);
            chk("groups loaded", rd[14:8], 7'h77);
        end
    endtask

    task automatic test_crystal();
        do_reset(GRP_PRI, MODE_XT);
        chk("src ext", src_sel_out, 5'h10);
        chk("pins crystal", pin_func_out, 4'h2);
        ticks(1023);
        chk("held before 1024", osc_clk_release_out, 0);
        ticks(1);
        chk("released at 1024", osc_clk_release_out, 1);
        @(posedge ref_clk_in);
        wake_in <= 1'b1;
        @(posedge ref_clk_in);
        wake_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        chk("wake restarts", osc_clk_release_out, 0);
        ticks(1024);
        chk("wake released", osc_clk_release_out, 1);
    endtask

    task automatic test_ext_pins();
        do_reset(GRP_PRI, MODE_EC);
        chk("ec no wait", osc_clk_release_out, 1);
        chk("ec clock out", pin_func_out, 4'h4);
        do_reset(GRP_PRI, MODE_EXTERNAL_RC_IO_MODE);
        chk("rc io no wait", osc_clk_release_out, 1);
        chk("rc io gpio", pin_func_out, 4'h8);
    endtask

    task automatic test_trim();
        logic [5:0] code [3];
        logic [7:0] ofs  [3];
        code = '{6'h1f, 6'h20, 6'h3f};
        ofs  = '{8'h3f, 8'hbf, 8'hfe};
        do_reset(GRP_FRC, MODE_XT);
        chk("src frc", src_sel_out, 5'h02);
        chk("trim reset", fast_rc_trim_out, TRIM_RST);
        for (int i = 0; i < 3; i++) begin
            bus_wr(TRIM_OFS, 32'(code[i]));
            chk("trim out", fast_rc_trim_out, code[i]);
            chk("trim offset", fast_rc_offset_out, ofs[i]);
            bus_rd(TRIM_OFS);
            chk("trim read", rd, 32'(code[i]));
        end
    endtask

    task automatic test_slow_rc();
        power_up_timer_expired_in <= 1'b0;
        do_reset(GRP_FRC, MODE_XT);
        chk("slow rc before power_up_timer", slow_rc_en_out, 1);
        power_up_timer_expired_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        chk("slow rc stops", slow_rc_en_out, 0);
        wdt_en_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        chk("slow rc watchdog", slow_rc_en_out, 1);
        wdt_en_in       <= 1'b0;
        fail_safe_en_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        chk("slow rc monitor", slow_rc_en_out, 1);
        fail_safe_en_in <= 1'b0;
        do_reset(GRP_SLOW_INTERNAL_RC, MODE_XT);
        chk("slow rc selected", slow_rc_en_out, 1);
        chk("src slow rc", src_sel_out, 5'h01);
    endtask

    task automatic test_secondary();
        do_reset(GRP_SEC, MODE_XT);
        chk("keep-on reset", secondary_osc_en_out, KEEP_RST);
        chk("no sec without keep", src_sel_out, 5'h00);
        bus_wr(CTRL_OFS, 32'h0000_0002);
        chk("keep-on runs osc", secondary_osc_en_out, 1);
        ticks(1024);
        chk("src secondary", src_sel_out, 5'h04);
        // back to the primary crystal through a switch request
        bus_wr(CTRL_OFS, 32'h0000_0303);
        chk("current group", current_group_out, GRP_PRI);
        chk("switch waits", osc_clk_release_out, 0);
        bus_rd(CTRL_OFS);
        chk("switch reads 0", rd[0], 0);
        ticks(1024);
        chk("primary released", osc_clk_release_out, 1);
    endtask

    task automatic test_lock_unmapped();
        pll_lock_in <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        bus_rd(CTRL_OFS);
        chk("lock set", rd[LOCK_BIT], 1);
        pll_lock_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        bus_rd(CTRL_OFS);
        chk("lock lost", rd[LOCK_BIT], 0);
        bus_wr(4'h8, 32'hffff_ffff);
        bus_rd(4'h8);
        chk("unmapped read", rd, 32'h0000_0000);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        ref_clk_in          = 1'b0;
        rst_in              = 1'b1;
        clock_group_cfg_in  = 3'h0;
        primary_mode_cfg_in = 5'h00;
        osc_tick_in         = 1'b0;
        pll_lock_in         = 1'b0;
        wake_in             = 1'b0;
        power_up_timer_expired_in     = 1'b1;
        wdt_en_in           = 1'b0;
        fail_safe_en_in     = 1'b0;
        avs_address_in      = 4'h0;
        avs_read_in         = 1'b0;
        avs_write_in        = 1'b0;
        avs_writedata_in    = 32'h0000_0000;
        avs_byteenable_in   = 4'hf;
        error_cnt           = 0;
        compares            = 0;
        test_pll_modes();
        test_crystal();
        test_ext_pins();
        test_trim();
        test_slow_rc();
        test_secondary();
        test_lock_unmapped();
        end_of_test();
    end
endmodule
